/* design/lotu_pkg.sv */
`default_nettype none
package lotu_pkg;
   // ------------------------------------------------------------
   // widths and field positions (bit 0 is the msb in these terms)
   // ------------------------------------------------------------
   localparam int unsigned WORD_W   = 32;
   localparam int unsigned HALF_W   = 16;
   localparam int unsigned BYTE_W   = 8;
   localparam int unsigned ADDR_W   = 24;
   // entry flag is printed bit 0 = vector bit 15
   localparam int unsigned ENT_FLAG = 15;
   // substitute char is printed bits 8:15 = vector bits 7:0
   localparam int unsigned CHR_HI   = 7;
   // half target is printed bits 1:15 = vector bits 14:0
   localparam int unsigned TGT_HI   = 14;
   localparam int unsigned TBL_ENTRIES = 256;
   localparam int unsigned BITARR_LOG2 = 27;

   // ------------------------------------------------------------
   // operation codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      LOTU_AND,
      LOTU_OR,
      LOTU_XOR
   } lotu_func_type;

   typedef enum logic [1:0] {
      LOTU_BYTE,
      LOTU_HALF,
      LOTU_FULL
   } lotu_size_type;

   localparam logic [WORD_W-1:0] WORD_ZERO = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 24'h00_0000;
   localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
endpackage
`default_nettype wire

/* design/lotu_boolean.sv */
`default_nettype none
module lotu_boolean #(
   parameter int unsigned W = 32
) (
   // operands and function
   input  wire logic [W-1:0]            opA,
   input  wire logic [W-1:0]            opB,
   input  wire lotu_pkg::lotu_func_type func,
   // result
   output logic      [W-1:0]            result
);
   import lotu_pkg::*;

   // per-bit boolean functions
   wire [W-1:0] andBits = opA & opB;
   wire [W-1:0] orBits  = opA | opB;
   wire [W-1:0] xorBits = opA ^ opB;

   // function select
   assign result = (func == LOTU_AND) ? andBits :
                   (func == LOTU_OR)  ? orBits  : xorBits;
endmodule
`default_nettype wire

/* design/lotu_logical_ops_translate_unit.sv */
// Summary of operation
// - halfword operand sign-widened into bits 0:15
// - and, or, xor on halfword and fullword
// - each bit combined independently
// - table offset is unsigned char doubled
// - flag set: bits 8:15 replace char
// - flag clear: branch to bits 1:15 doubled
// - branch target is 16-bit, low 64kb
// - target is program address, relocatable
`default_nettype none
module lotu_logical_ops_translate_unit
   import lotu_pkg::*;
#(
   parameter int unsigned TABLE_ENTRIES = lotu_pkg::TBL_ENTRIES
) (
   // clock and reset
   input  wire logic                          core_clk,
   input  wire logic                          rst_b,
   // boolean operation request
   input  wire logic                          opValid,
   input  wire lotu_pkg::lotu_func_type       opFunc,
   input  wire lotu_pkg::lotu_size_type       opSize,
   input  wire logic [lotu_pkg::WORD_W-1:0]   regOperand,
   input  wire logic [lotu_pkg::WORD_W-1:0]   memOperand,
   // boolean result
   output logic                               resValid,
   output logic      [lotu_pkg::WORD_W-1:0]   resData,
   // translate request
   input  wire logic                          xlatValid,
   input  wire logic [lotu_pkg::BYTE_W-1:0]   xlatChar,
   input  wire logic [lotu_pkg::ADDR_W-1:0]   tableBase,
   // table fetch to memory operand path
   output logic                               tblReq,
   output logic      [lotu_pkg::ADDR_W-1:0]   tblAddr,
   input  wire logic                          tblAck,
   input  wire logic [lotu_pkg::HALF_W-1:0]   tblEntry,
   // translate result
   output logic                               xlatDone,
   output logic                               xlatBranch,
   output logic      [lotu_pkg::BYTE_W-1:0]   xlatSubst,
   output logic      [lotu_pkg::HALF_W-1:0]   xlatTarget
);
   // ------------------------------------------------------------
   // boolean datapath
   // ------------------------------------------------------------
   // bit 0 (msb) is vector bit 31; widen halfword by its sign
   // printed bit 0 is always the top bit of the vector
   wire              halfSign = memOperand[HALF_W-1];
   wire [WORD_W-1:0] halfWide =
      {{(WORD_W-HALF_W){halfSign}}, memOperand[HALF_W-1:0]};

   // byte operands take zeros above their eight bits
   wire [WORD_W-1:0] byteWide =
      {{(WORD_W-BYTE_W){1'b0}}, memOperand[BYTE_W-1:0]};

   // second operand after widening to a fullword
   wire [WORD_W-1:0] opB =
      (opSize == LOTU_HALF) ? halfWide :
      (opSize == LOTU_BYTE) ? byteWide : memOperand;

   // combined result ahead of the result register
   wire [WORD_W-1:0] boolOut;

   lotu_boolean #(.W(WORD_W)) uBool (
      .opA    (regOperand),
      .opB    (opB),
      .func   (opFunc),
      .result (boolOut)
   );

   // next values of the result registers
   logic              resValid_d;
   logic [WORD_W-1:0] resData_d;
   assign resValid_d = opValid;
   assign resData_d  = opValid ? boolOut : resData;

   // result valid pulse, one cycle after the request
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         resValid <= 1'b0;
      end else begin
         resValid <= resValid_d;
      end
   end

   // result data; holds the last result between requests
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         resData <= WORD_ZERO;
      end else begin
         resData <= resData_d;
      end
   end

   // ------------------------------------------------------------
   // translate sequencer
   // ------------------------------------------------------------
   // requests that arrive while busy are dropped with no sign;
   // the caller waits for the done pulse before the next one
   typedef enum logic [1:0] {
      LOTU_IDLE,
      LOTU_FETCH,
      LOTU_DONE
   } lotu_state_type;

   lotu_state_type state_q, state_d;

   // offset is unsigned char times two; index masked to table size
   wire [BYTE_W-1:0] charIdx = xlatChar &
      BYTE_W'(TABLE_ENTRIES - 1);
   wire [ADDR_W-1:0] entryOff =
      {{(ADDR_W-BYTE_W-1){1'b0}}, charIdx, 1'b0};
   wire [ADDR_W-1:0] entryAddr = tableBase + entryOff;

   // entry decode
   wire              entryIsChar = tblEntry[ENT_FLAG];
   wire [BYTE_W-1:0] entryChar   = tblEntry[CHR_HI:0];
   // 16-bit program target, relocation done downstream
   wire [HALF_W-1:0] entryTgt    = {tblEntry[TGT_HI:0], 1'b0};

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         LOTU_IDLE:  if (xlatValid) state_d = LOTU_FETCH;
         LOTU_FETCH: if (tblAck)    state_d = LOTU_DONE;
         LOTU_DONE:  state_d = LOTU_IDLE;
         default:    state_d = LOTU_IDLE;
      endcase
   end


   // handshake decodes
   wire takeReq  = (state_q == LOTU_IDLE) && xlatValid;
   wire takeResp = (state_q == LOTU_FETCH) && tblAck;

   // result loads by entry kind
   wire loadSubst = takeResp && entryIsChar;
   wire loadTgt   = takeResp && !entryIsChar;

   // state register
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= LOTU_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // ------------------------------------------------------------
   // fetch interface
   // ------------------------------------------------------------
   // fetch request level, raised on take and dropped on the ack edge
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tblReq <= 1'b0;
      end else if (takeReq) begin
         tblReq <= 1'b1;
      end else if (takeResp) begin
         tblReq <= 1'b0;
      end
   end

   // fetch address, captured once so it stands until the ack
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         tblAddr <= ADDR_ZERO;
      end else if (takeReq) begin
         tblAddr <= entryAddr;
      end
   end

   // ------------------------------------------------------------
   // translate result
   // ------------------------------------------------------------
   // done pulse, raised on the ack edge for one cycle
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         xlatDone <= 1'b0;
      end else begin
         xlatDone <= takeResp;
      end
   end

   // branch flag for the finished translate
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         xlatBranch <= 1'b0;
      end else if (takeResp) begin
         xlatBranch <= !entryIsChar;
      end
   end

   // substitute char; holds over branch results
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         xlatSubst <= BYTE_ZERO;
      end else if (loadSubst) begin
         xlatSubst <= entryChar;
      end
   end

   // branch target; holds over substitute results
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         xlatTarget <= {HALF_W{1'b0}};
      end else if (loadTgt) begin
         xlatTarget <= entryTgt;
      end
   end
endmodule
`default_nettype wire

/* sim/lotu_chk.sv */
`default_nettype none
module lotu_chk
   import lotu_pkg::*;
(
   // clock, reset and boolean path
   input wire logic                    core_clk,
   input wire logic                    rst_b,
   input wire logic                    opValid,
   input wire lotu_pkg::lotu_func_type opFunc,
   input wire lotu_pkg::lotu_size_type opSize,
   input wire logic [31:0]             regOperand,
   input wire logic [31:0]             memOperand,
   input wire logic                    resValid,
   input wire logic [31:0]             resData,
   // translate path
   input wire logic                    xlatValid,
   input wire logic [7:0]              xlatChar,
   input wire logic [23:0]             tableBase,
   input wire logic                    tblReq,
   input wire logic [23:0]             tblAddr,
   input wire logic                    tblAck,
   input wire logic [15:0]             tblEntry,
   input wire logic                    xlatDone,
   input wire logic                    xlatBranch,
   input wire logic [7:0]              xlatSubst,
   input wire logic [15:0]             xlatTarget
);
   // widened second operands
   wire logic [31:0] halfExt = {{16{memOperand[15]}}, memOperand[15:0]};
   wire logic [31:0] byteExt = {24'h0, memOperand[7:0]};
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------
   // request and fetch steps
   // ------------------------------
   sequence take_s;
      xlatValid && !tblReq && !xlatDone;
   endsequence
   sequence fetch_s;
      tblReq && tblAck;
   endsequence
   res_pulse_a: assert property (opValid |=> resValid)
      else $error("result pulse missing");
   and_full_a: assert property (opValid && opFunc == LOTU_AND &&
      opSize == LOTU_FULL |=> resData == ($past(regOperand) & $past(memOperand)))
      else $error("fullword and wrong");
   half_sign_a: assert property (opValid && opFunc == LOTU_OR &&
      opSize == LOTU_HALF |=> resData == ($past(regOperand) | $past(halfExt)))
      else $error("halfword widening wrong");
   byte_zero_a: assert property (opValid && opFunc == LOTU_XOR &&
      opSize == LOTU_BYTE |=> resData == ($past(regOperand) ^ $past(byteExt)))
      else $error("byte xor wrong");
   tbl_addr_a: assert property (take_s |=> tblReq &&
      tblAddr == 24'($past(tableBase) + {$past(xlatChar), 1'h0}))
      else $error("table address wrong");
   req_hold_a: assert property (tblReq && !tblAck |=> tblReq && $stable(tblAddr))
      else $error("fetch not held");
   subst_a: assert property (fetch_s ##0 tblEntry[15] |=> xlatDone &&
      !xlatBranch && xlatSubst == 8'($past(tblEntry))) else $error("subst wrong");
   branch_a: assert property (fetch_s ##0 !tblEntry[15] |=> xlatDone &&
      xlatBranch && xlatTarget == 16'($past(tblEntry) << 1)) else $error("target wrong");
endmodule
bind lotu_logical_ops_translate_unit lotu_chk u_chk (.*);
`default_nettype wire

/* sim/lotu_logical_ops_translate_unit_test.sv */
`default_nettype none
module lotu_logical_ops_translate_unit_test
   import lotu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 1'h0, rst_b = 1'h0, opValid = 1'h0, xlatValid = 1'h0;
   logic tblAck = 1'h0, resValid, tblReq, xlatDone, xlatBranch;
   lotu_func_type opFunc = LOTU_AND;
   lotu_size_type opSize = LOTU_FULL;
   logic [31:0] regOperand = 32'h0, memOperand = 32'h0, resData;
   logic [23:0] tableBase = 24'h0, tblAddr;
   logic [15:0] tblEntry = 16'h0, xlatTarget;
   logic [7:0] xlatChar = 8'h0, xlatSubst;
   logic [31:0] expQ[$];
   int fails = 0, checked = 0, n;
   always #25 core_clk = ~core_clk;
   lotu_logical_ops_translate_unit dut (.*);
   // ------------------------------
   // compare, verdict and model
   // ------------------------------
   task automatic chk(logic [32:0] g, logic [32:0] x);
      checked++;
      if (g !== x) begin
         fails++;
         $display("Error at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic results();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   function automatic logic [31:0] model(int f, int s, logic [31:0] a, b);
      b = s == 2 ? b : s == 1 ? {{16{b[15]}}, b[15:0]} : {24'h0, b[7:0]};
      return f == 0 ? a & b : f == 1 ? a | b : a ^ b;
   endfunction
   // one translate with a table fetch answered at once
   task automatic xlat(logic [7:0] c, logic [15:0] ent);
      @(negedge core_clk);
      xlatValid = 1'h1;
      xlatChar = c;
      tableBase = 24'($urandom);
      @(negedge core_clk);
      xlatValid = 1'h0;
      for (n = 0; n < 8 && tblReq !== 1'h1; n++) @(negedge core_clk);
      if (tblReq !== 1'h1) begin
         fails++;
         $display("Error at %0t: fetch request timed out", $time);
         results();
      end
      chk(tblAddr, 24'(tableBase + {c, 1'h0}));
      tblAck = 1'h1;
      tblEntry = ent;
      @(negedge core_clk);
      tblAck = 1'h0;
      tblEntry = ~ent;
      chk({xlatDone, xlatBranch}, {1'h1, !ent[15]});
      if (ent[15]) chk(xlatSubst, ent[7:0]);
      else chk(xlatTarget, {ent[14:0], 1'h0});
   endtask
   // back-to-back boolean ops over every function and size, then translates
   initial begin
      void'($urandom(32'h7354));
      repeat (16) @(negedge core_clk);
      chk({resValid, tblReq, xlatDone}, 3'h0);
      rst_b = 1'h1;
      for (int i = 0; i < 30; i++) begin
         @(negedge core_clk);
         if (i > 0) chk({resValid, resData}, {1'h1, expQ.pop_front()});
         opValid = 1'h1;
         opFunc = lotu_func_type'(i % 3);
         opSize = lotu_size_type'(i / 3 % 3);
         regOperand = $urandom;
         memOperand = i == 3 ? 32'h0000_a000 : $urandom;
         expQ.push_back(model(i % 3, i / 3 % 3, regOperand, memOperand));
      end
      @(negedge core_clk);
      opValid = 1'h0;
      chk({resValid, resData}, {1'h1, expQ.pop_front()});
      @(negedge core_clk);
      chk(resValid, 1'h0);
      xlat(8'hff, 16'h80a5);
      xlat(8'h00, 16'h7fff);
      repeat (8) xlat(8'($urandom), 16'($urandom));
      results();
   end
endmodule
`default_nettype wire
